// *** rtl/pllcal_ahb_slave.sv ***
// AHB-Lite slave front end: turns bus transfers into register strobes.
// Assumes single word transfers; writes take no wait state, reads take one.
`timescale 1ns/1ps
module pllcal_ahb_slave (
    input wire logic clock,
    input wire logic rst_sync_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata
);
    logic wr_ph_reg, wr_ph_next;
    logic rd_ph_reg, rd_ph_next;
    logic rd_hold_reg, rd_hold_next;
    logic [7:0] addr_reg, addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic accept;

    // The read waits one cycle because hrdata comes from rdata_reg, which is loaded in the first data cycle.
    always_comb begin
        accept = hsel && htrans[1] && hready;
        wr_ph_next = accept && hwrite;
        rd_hold_next = rd_ph_reg && !rd_hold_reg;
        rd_ph_next = (accept && !hwrite) || (rd_ph_reg && !rd_hold_reg);
        addr_next = accept ? haddr[7:0] : addr_reg;
        rdata_next = (rd_ph_reg && !rd_hold_reg) ? reg_rdata : rdata_reg;
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wr_ph_reg <= 1'b0;
            rd_ph_reg <= 1'b0;
            rd_hold_reg <= 1'b0;
            addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wr_ph_reg <= wr_ph_next;
            rd_ph_reg <= rd_ph_next;
            rd_hold_reg <= rd_hold_next;
            addr_reg <= addr_next;
            rdata_reg <= rdata_next;
        end
    end

    assign hreadyout = !(rd_ph_reg && !rd_hold_reg);
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign reg_wr = wr_ph_reg;
    assign reg_addr = addr_reg;
    assign reg_wdata = hwdata;
endmodule

// *** rtl/pllcal_cfg.svh ***
// Register offsets, field positions, reset values and counts for the PLL calibration block.
// Assumes the includer compiles after pllcal_pkg.
`ifndef PLLCAL_CFG_SVH
`define PLLCAL_CFG_SVH
`define PLLCAL_A_CAL 8'h00
`define PLLCAL_A_MAIN 8'h04
`define PLLCAL_A_VRES 8'h08
`define PLLCAL_A_PRES 8'h0c
`define PLLCAL_A_VOVR 8'h10
`define PLLCAL_A_POVR 8'h14
`define PLLCAL_A_RDIV 8'h18
`define PLLCAL_A_RXBUF 8'h1c
`define PLLCAL_F_START 7
`define PLLCAL_F_DUAL 6
`define PLLCAL_F_WAIT 5
`define PLLCAL_F_CUR 4
`define PLLCAL_F_DONE 3
`define PLLCAL_F_SLOT 0
`define PLLCAL_F_HISIDE 1
`define PLLCAL_F_VOV_EN 4
`define PLLCAL_F_PDIS 5
`define PLLCAL_F_POV_EN 5
`define PLLCAL_CAL_RST 8'h05
`define PLLCAL_VOVR_RST 6'h08
`define PLLCAL_POVR_RST 6'h10
`define PLLCAL_RDIV_RST 8'h04
`define PLLCAL_FULL_REF 25650
`define PLLCAL_HALF_REF 12825
`define PLLCAL_STEP_SHIFT 10
`define PLLCAL_VCO_STEPS 4'h4
`define PLLCAL_LAST_STEP 4'h8
`define PLLCAL_VCO_TRIAL 4'h8
`define PLLCAL_PUMP_TRIAL 5'h10
`endif

// *** rtl/pllcal_pkg.sv ***
// Types shared by the PLL calibration block.
// Assumes nothing of its surroundings.
package pllcal_pkg;
    typedef enum logic [1:0] {
        PC_IDLE = 2'b00,
        PC_RUN = 2'b01,
        PC_DONE = 2'b10
    } pllcal_state_t;
    typedef logic [3:0] pllcal_vco_t;
    typedef logic [4:0] pllcal_pump_t;
endpackage

// *** rtl/pllcal_top.sv ***
// PLL self-calibration control: register file, reference divider, calibration sequencer
// and per-slot result storage. Assumes an AHB-Lite master and an analog synthesizer that
// reports whether the VCO and the loop lie above target for the trial settings it gets.
`timescale 1ns/1ps
`include "pllcal_cfg.svh"
// Notes on behaviour
// - Engine searches VCO range and pump current itself.
// - Wait bit one: done after 25650 ref cycles.
// - Wait bit zero: done after 12825 ref cycles.
// - Clearing start bit clears the done flag.
// - Results kept until reset or the next calibration.
// - Separate result set for slot A and B.
// - Dual bit selects one or both slots.
// - Results land in VCO and pump status registers.
// - Slot select bit picks which result copy reads.
// - Saved values not written into override fields.
// - Overrides apply only with both enables set.
// - High-side injection inverts received buffer bits.
// - Start on rising edge; bit stays until cleared.
// - Dual stores both slots, else selected one.
module pllcal_top #(
    parameter int unsigned FULL_REF = `PLLCAL_FULL_REF,
    parameter int unsigned HALF_REF = `PLLCAL_HALF_REF,
    parameter int unsigned STEP_SHIFT = `PLLCAL_STEP_SHIFT,
    parameter int unsigned CNT_W = 15
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic vco_above_target,
    input wire logic pump_above_target,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    output pllcal_pkg::pllcal_vco_t vco_array_out,
    output pllcal_pkg::pllcal_pump_t pump_current_out,
    output logic cal_active,
    output logic cal_current_double,
    output logic [2:0] cal_dac_start_value,
    output logic pump_disable
);
    import pllcal_pkg::*;

    logic rst_s1_reg, rst_s2_reg, rst_sync_n;
    logic reg_wr;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;

    // Register group.
    logic [7:0] cal_reg, cal_next;
    logic [1:0] main_reg, main_next;
    logic [5:0] vovr_reg, vovr_next;
    logic [5:0] povr_reg, povr_next;
    logic [7:0] rdiv_reg, rdiv_next;
    logic [7:0] rxbuf_reg, rxbuf_next;

    // Calibration group.
    pllcal_state_t state_reg, state_next;
    logic start_q_reg, start_q_next;
    logic done_reg, done_next;
    logic [CNT_W-1:0] refcnt_reg, refcnt_next;
    logic [7:0] divcnt_reg, divcnt_next;
    pllcal_vco_t vtrial_reg, vtrial_next;
    pllcal_pump_t ptrial_reg, ptrial_next;
    pllcal_vco_t vres_reg [2];
    pllcal_vco_t vres_next [2];
    pllcal_pump_t pres_reg [2];
    pllcal_pump_t pres_next [2];
    pllcal_vco_t vout_reg, vout_next;
    pllcal_pump_t pout_reg, pout_next;

    logic start_bit, slot, ovr_both, tick, step_end, finish;
    logic [3:0] step;
    logic [CNT_W-1:0] last_cnt;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_sync_n = rst_s2_reg;

    pllcal_ahb_slave u_bus (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    assign start_bit = cal_reg[`PLLCAL_F_START];
    assign slot = main_reg[`PLLCAL_F_SLOT];
    assign ovr_both = vovr_reg[`PLLCAL_F_VOV_EN] && povr_reg[`PLLCAL_F_POV_EN];

    always_comb begin
        cal_next = cal_reg;
        main_next = main_reg;
        vovr_next = vovr_reg;
        povr_next = povr_reg;
        rdiv_next = rdiv_reg;
        rxbuf_next = rxbuf_reg;
        if (reg_wr) begin
            case (reg_addr)
                `PLLCAL_A_CAL: cal_next = reg_wdata[7:0] & ~(8'h01 << `PLLCAL_F_DONE);
                `PLLCAL_A_MAIN: main_next = reg_wdata[1:0];
                `PLLCAL_A_VOVR: vovr_next = reg_wdata[5:0];
                `PLLCAL_A_POVR: povr_next = reg_wdata[5:0];
                `PLLCAL_A_RDIV: rdiv_next = reg_wdata[7:0];
                default: cal_next = cal_reg;
            endcase
        end
        if (rx_byte_valid) begin
            rxbuf_next = main_reg[`PLLCAL_F_HISIDE] ? ~rx_byte : rx_byte;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cal_reg <= `PLLCAL_CAL_RST;
            main_reg <= 2'h0;
            vovr_reg <= `PLLCAL_VOVR_RST;
            povr_reg <= `PLLCAL_POVR_RST;
            rdiv_reg <= `PLLCAL_RDIV_RST;
            rxbuf_reg <= 8'h00;
        end else begin
            cal_reg <= cal_next;
            main_reg <= main_next;
            vovr_reg <= vovr_next;
            povr_reg <= povr_next;
            rdiv_reg <= rdiv_next;
            rxbuf_reg <= rxbuf_next;
        end
    end

    // Reads of the result addresses see the copy picked by the slot bit.
    always_comb begin
        case (reg_addr)
            `PLLCAL_A_CAL: reg_rdata = {24'h000000, cal_reg[7:4], done_reg, cal_reg[2:0]};
            `PLLCAL_A_MAIN: reg_rdata = {30'h00000000, main_reg};
            `PLLCAL_A_VRES: reg_rdata = {28'h0000000, vres_reg[slot]};
            `PLLCAL_A_PRES: reg_rdata = {27'h0000000, pres_reg[slot]};
            `PLLCAL_A_VOVR: reg_rdata = {26'h0000000, vovr_reg};
            `PLLCAL_A_POVR: reg_rdata = {26'h0000000, povr_reg};
            `PLLCAL_A_RDIV: reg_rdata = {24'h000000, rdiv_reg};
            `PLLCAL_A_RXBUF: reg_rdata = {24'h000000, rxbuf_reg};
            default: reg_rdata = 32'h0000_0000;
        endcase
    end

    // One reference cycle lasts rdiv_reg clocks; zero is treated as one.
    assign tick = ({1'b0, divcnt_reg} + 9'h001) >= {1'b0, rdiv_reg};
    // The step index saturates past the last step, so a long wait never wraps back
    // into the search and disturbs trial bits that are already settled.
    assign step = ((refcnt_reg >> STEP_SHIFT) > CNT_W'(`PLLCAL_LAST_STEP))
        ? 4'hf : 4'(refcnt_reg >> STEP_SHIFT);
    assign step_end = tick && (&refcnt_reg[STEP_SHIFT-1:0]);
    assign last_cnt = cal_reg[`PLLCAL_F_WAIT] ? CNT_W'(FULL_REF - 1) : CNT_W'(HALF_REF - 1);
    assign finish = (state_reg == PC_RUN) && tick && (refcnt_reg == last_cnt);

    always_comb begin
        logic [1:0] vb;
        logic [2:0] pb;
        vb = 2'(3 - step);
        pb = 3'(8 - step);
        state_next = state_reg;
        start_q_next = start_bit;
        done_next = done_reg && start_bit;
        refcnt_next = refcnt_reg;
        divcnt_next = divcnt_reg;
        vtrial_next = vtrial_reg;
        ptrial_next = ptrial_reg;
        vres_next = vres_reg;
        pres_next = pres_reg;
        case (state_reg)
            PC_IDLE, PC_DONE: begin
                if (start_bit && !start_q_reg) begin
                    state_next = PC_RUN;
                    refcnt_next = '0;
                    divcnt_next = 8'h00;
                    vtrial_next = `PLLCAL_VCO_TRIAL;
                    ptrial_next = `PLLCAL_PUMP_TRIAL;
                    done_next = 1'b0;
                end else if (!start_bit) begin
                    state_next = PC_IDLE;
                end
            end
            PC_RUN: begin
                divcnt_next = tick ? 8'h00 : divcnt_reg + 8'h01;
                if (tick) begin
                    refcnt_next = refcnt_reg + CNT_W'(1);
                end
                // Successive approximation: keep a trial bit unless the loop reads high.
                if (step_end && step < `PLLCAL_VCO_STEPS) begin
                    vtrial_next[vb] = !vco_above_target;
                    if (vb != 2'h0) begin
                        vtrial_next[vb - 2'h1] = 1'b1;
                    end
                end else if (step_end && step <= `PLLCAL_LAST_STEP) begin
                    ptrial_next[pb] = !pump_above_target;
                    if (pb != 3'h0) begin
                        ptrial_next[pb - 3'h1] = 1'b1;
                    end
                end
                if (!start_bit) begin
                    state_next = PC_IDLE;
                end
                if (finish) begin
                    done_next = 1'b1;
                    state_next = start_bit ? PC_DONE : PC_IDLE;
                    for (int i = 0; i < 2; i++) begin
                        if (cal_reg[`PLLCAL_F_DUAL] || (slot == 1'(i))) begin
                            vres_next[i] = vtrial_reg;
                            pres_next[i] = ptrial_reg;
                        end
                    end
                end
            end
            default: state_next = PC_IDLE;
        endcase
        if (state_reg == PC_RUN) begin
            vout_next = vtrial_reg;
            pout_next = ptrial_reg;
        end else if (ovr_both) begin
            vout_next = vovr_reg[3:0];
            pout_next = povr_reg[4:0];
        end else begin
            vout_next = vres_reg[slot];
            pout_next = pres_reg[slot];
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg <= PC_IDLE;
            start_q_reg <= 1'b0;
            done_reg <= 1'b0;
            refcnt_reg <= '0;
            divcnt_reg <= 8'h00;
            vtrial_reg <= `PLLCAL_VCO_TRIAL;
            ptrial_reg <= `PLLCAL_PUMP_TRIAL;
            vres_reg[0] <= `PLLCAL_VCO_TRIAL;
            vres_reg[1] <= `PLLCAL_VCO_TRIAL;
            pres_reg[0] <= `PLLCAL_PUMP_TRIAL;
            pres_reg[1] <= `PLLCAL_PUMP_TRIAL;
            vout_reg <= `PLLCAL_VCO_TRIAL;
            pout_reg <= `PLLCAL_PUMP_TRIAL;
        end else begin
            state_reg <= state_next;
            start_q_reg <= start_q_next;
            done_reg <= done_next;
            refcnt_reg <= refcnt_next;
            divcnt_reg <= divcnt_next;
            vtrial_reg <= vtrial_next;
            ptrial_reg <= ptrial_next;
            vres_reg <= vres_next;
            pres_reg <= pres_next;
            vout_reg <= vout_next;
            pout_reg <= pout_next;
        end
    end

    assign vco_array_out = vout_reg;
    assign pump_current_out = pout_reg;
    assign cal_active = (state_reg == PC_RUN);
    assign cal_current_double = cal_reg[`PLLCAL_F_CUR];
    assign cal_dac_start_value = cal_reg[2:0];
    assign pump_disable = vovr_reg[`PLLCAL_F_PDIS];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_n);

    sequence s_rise;
        start_bit && !start_q_reg && (state_reg != PC_RUN);
    endsequence
    sequence s_finish;
        finish ##1 done_reg;
    endsequence

    property p_start_edge;
        s_rise |=> cal_active && !done_reg;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("rising start did not run");

    property p_full_wait;
        $rose(done_reg) |-> $past(cal_reg[`PLLCAL_F_WAIT]) == 1'b0
            || $past(refcnt_reg) == CNT_W'(FULL_REF - 1);
    endproperty
    a_full_wait: assert property (p_full_wait) else $error("full wait count wrong");

    property p_half_wait;
        $rose(done_reg) |-> $past(cal_reg[`PLLCAL_F_WAIT]) == 1'b1
            || $past(refcnt_reg) == CNT_W'(HALF_REF - 1);
    endproperty
    a_half_wait: assert property (p_half_wait) else $error("half wait count wrong");

    property p_clear_done;
        !start_bit && !finish |=> !done_reg;
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("done not cleared");

    property p_override;
        ovr_both && !cal_active |=> vco_array_out == $past(vovr_reg[3:0])
            && pump_current_out == $past(povr_reg[4:0]);
    endproperty
    a_override: assert property (p_override) else $error("override not applied");

    property p_dual_store;
        finish && cal_reg[`PLLCAL_F_DUAL] |=> vres_reg[0] == vres_reg[1]
            && pres_reg[0] == pres_reg[1];
    endproperty
    a_dual_store: assert property (p_dual_store) else $error("dual store missed");

    property p_single_store;
        finish && !cal_reg[`PLLCAL_F_DUAL] |=> $stable(vres_reg[!slot])
            && $stable(pres_reg[!slot]);
    endproperty
    a_single_store: assert property (p_single_store) else $error("other slot changed");

    property p_result;
        s_finish |-> vres_reg[slot] == $past(vtrial_reg, 2) && !cal_active;
    endproperty
    a_result: assert property (p_result) else $error("result not stored");

    property p_rx_invert;
        rx_byte_valid && main_reg[`PLLCAL_F_HISIDE] |=> rxbuf_reg == ~$past(rx_byte);
    endproperty
    a_rx_invert: assert property (p_rx_invert) else $error("buffer not inverted");
endmodule

// *** test/pllcal_bench.sv ***
// Self-checking bench for the PLL calibration block, driven over AHB-Lite.
// Assumes the block answers writes at once and reads after one wait state.
`timescale 1ns/1ps
`include "pllcal_cfg.svh"
module pllcal_bench;
    import pllcal_pkg::*;
    // Short counts keep each calibration run to a few thousand cycles.
    localparam int FULL = 2600;
    localparam int HALF = 1300;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic vco_above_target = 1'b0;
    logic pump_above_target = 1'b0;
    logic rx_byte_valid = 1'b0;
    logic [7:0] rx_byte = 8'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    pllcal_vco_t vco_array_out;
    pllcal_pump_t pump_current_out;
    logic cal_active;
    logic cal_current_double;
    logic [2:0] cal_dac_start_value;
    logic pump_disable;
    pllcal_vco_t tgt_v = 4'h0;
    pllcal_pump_t tgt_p = 5'h0;
    pllcal_vco_t ev [2] = '{4'h8, 4'h8};
    pllcal_pump_t ep [2] = '{5'h10, 5'h10};
    int error_cnt = 0;
    int n_checks = 0;
    int seed = 32'h1f818cd2;
    logic [31:0] r;

    pllcal_top #(.FULL_REF(FULL), .HALF_REF(HALF), .STEP_SHIFT(7), .CNT_W(15)) i_dut (
        .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .vco_above_target(vco_above_target), .pump_above_target(pump_above_target),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .vco_array_out(vco_array_out),
        .pump_current_out(pump_current_out), .cal_active(cal_active),
        .cal_current_double(cal_current_double), .cal_dac_start_value(cal_dac_start_value),
        .pump_disable(pump_disable)
    );

    // Stand-in for the analog comparators: a trial above the target reads as too high.
    always @(posedge clock) begin
        vco_above_target <= vco_array_out > tgt_v;
        pump_above_target <= pump_current_out > tgt_p;
    end

    initial begin
        forever #2.5 clock = ~clock;
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wait_ready();
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (hreadyout === 1'b1) break;
        end
        if (i == 50) begin
            error_cnt++;
            $display("unexpected bus wait: expected ready, seen timeout");
            final_report();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(n, x, exp);
    endtask

    task automatic wait_idle(output int cnt);
        int lim;
        cnt = 0;
        for (lim = 0; lim < 10 && cal_active !== 1'b1; lim++) @(posedge clock);
        while (cal_active === 1'b1 && cnt < 20000) begin
            @(posedge clock);
            cnt++;
        end
        if (cnt == 20000) begin
            check("cal end", 32'h0, 32'h1);
            final_report();
        end
    endtask

    task automatic cal_run(input logic dual, input logic slot, input logic full,
                           input logic [7:0] div, input pllcal_vco_t v, input pllcal_pump_t p);
        int n;
        int cnt;
        logic [7:0] c;
        c = {1'b1, dual, full, dual, 1'b0, 3'b110};
        n = (full ? FULL : HALF) * div;
        tgt_v = v;
        tgt_p = p;
        wr(`PLLCAL_A_RDIV, {24'h0, div});
        wr(`PLLCAL_A_MAIN, {31'h0, slot});
        wr(`PLLCAL_A_CAL, {24'h0, c});
        wait_idle(cnt);
        check("cal length in range", {31'h0, cnt >= n - 1 && cnt <= n + div}, 32'h1);
        check("current double", {31'h0, cal_current_double}, {31'h0, dual});
        check("dac start", {29'h0, cal_dac_start_value}, 32'h6);
        rd_chk("done flag", `PLLCAL_A_CAL, {24'h0, c | 8'h08});
        if (dual || !slot) begin
            ev[0] = v;
            ep[0] = p;
        end
        if (dual || slot) begin
            ev[1] = v;
            ep[1] = p;
        end
        wr(`PLLCAL_A_CAL, {24'h0, c & 8'h7f});
        rd_chk("done cleared", `PLLCAL_A_CAL, {24'h0, c & 8'h77});
        for (int s = 0; s < 2; s++) begin
            wr(`PLLCAL_A_MAIN, s);
            rd_chk("vco result", `PLLCAL_A_VRES, {28'h0, ev[s]});
            rd_chk("pump result", `PLLCAL_A_PRES, {27'h0, ep[s]});
            cyc(2);
            check("vco applied", {28'h0, vco_array_out}, {28'h0, ev[s]});
            check("pump applied", {27'h0, pump_current_out}, {27'h0, ep[s]});
        end
        $display("calibration run dual %0d slot %0d done", dual, slot);
    endtask

    initial begin
        logic [7:0] b;
        int cnt;
        logic [7:0] regs [8];
        logic [7:0] rstv [8];
        regs = '{`PLLCAL_A_CAL, `PLLCAL_A_MAIN, `PLLCAL_A_VRES,
            `PLLCAL_A_PRES, `PLLCAL_A_VOVR, `PLLCAL_A_POVR, `PLLCAL_A_RDIV, 8'h40};
        rstv = '{8'h05, 8'h00, 8'h08, 8'h10, 8'h08, 8'h10, 8'h04, 8'h00};
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        cyc(3);
        check("vco after reset", {28'h0, vco_array_out}, 32'h8);
        check("pump after reset", {27'h0, pump_current_out}, 32'h10);
        check("dac after reset", {29'h0, cal_dac_start_value}, 32'h5);
        check("active after reset", {31'h0, cal_active}, 32'h0);
        wr(8'h40, 32'hff);
        wr(`PLLCAL_A_VRES, 32'h3);
        for (int i = 0; i < 8; i++) rd_chk("reset value", regs[i], {24'h0, rstv[i]});
        $display("reset and map test done");
        cal_run(1'b0, 1'b0, 1'b0, 8'h1, 4'h0, 5'h1f);
        cal_run(1'b0, 1'b1, 1'b1, 8'h2, 4'hf, 5'h00);
        cal_run(1'b1, 1'b0, 1'b0, 8'h1, 4'h5, 5'h0a);
        for (int k = 0; k < 3; k++) begin
            r = $random(seed);
            cal_run(r[0], r[1], r[2], {7'h0, r[3]} + 8'h1, r[7:4], r[12:8]);
        end
        // Abort mid-run, then a complete half-wait run whose start bit is written again while still set.
        wr(`PLLCAL_A_RDIV, 32'h1);
        tgt_v = ~ev[1];
        wr(`PLLCAL_A_CAL, 32'h86);
        cyc(50);
        wr(`PLLCAL_A_CAL, 32'h06);
        cyc(3);
        check("abort stops run", {31'h0, cal_active}, 32'h0);
        rd_chk("abort keeps result", `PLLCAL_A_VRES, {28'h0, ev[1]});
        wr(`PLLCAL_A_CAL, 32'h86);
        wait_idle(cnt);
        check("restart runs", {31'h0, cnt >= HALF - 1 && cnt <= HALF + 1}, 32'h1);
        wr(`PLLCAL_A_CAL, 32'h86);
        cyc(4);
        check("no restart on level", {31'h0, cal_active}, 32'h0);
        rd_chk("done stands", `PLLCAL_A_CAL, 32'h8e);
        wr(`PLLCAL_A_CAL, 32'h06);
        ev[1] = tgt_v;
        ep[1] = tgt_p;
        $display("abort and retrigger test done");
        r = $random(seed);
        wr(`PLLCAL_A_VOVR, {26'h0, 2'b01, r[3:0]});
        cyc(2);
        check("one enable only", {28'h0, vco_array_out}, {28'h0, ev[1]});
        wr(`PLLCAL_A_POVR, {26'h0, 1'b1, r[8:4]});
        cyc(2);
        check("vco_array_override_en", {28'h0, vco_array_out}, {28'h0, r[3:0]});
        check("pump override", {27'h0, pump_current_out}, {27'h0, r[8:4]});
        rd_chk("pump ovr readback", `PLLCAL_A_POVR, {26'h0, 1'b1, r[8:4]});
        wr(`PLLCAL_A_VOVR, {26'h0, 2'b10, r[3:0]});
        cyc(2);
        check("pump disable", {31'h0, pump_disable}, 32'h1);
        check("vco enable off", {28'h0, vco_array_out}, {28'h0, ev[1]});
        wr(`PLLCAL_A_VOVR, 32'h08);
        wr(`PLLCAL_A_POVR, 32'h10);
        $display("override test done");
        for (int hs = 0; hs < 2; hs++) begin
            wr(`PLLCAL_A_MAIN, hs * 2);
            r = $random(seed);
            b = r[7:0];
            @(posedge clock);
            rx_byte <= b;
            rx_byte_valid <= 1'b1;
            @(posedge clock);
            rx_byte_valid <= 1'b0;
            rd_chk("rx buffer", `PLLCAL_A_RXBUF, {24'h0, hs ? ~b : b});
        end
        $display("receive polarity test done");
        final_report();
    end
endmodule
